// ---- logic/aout_card_pkg.sv ----
/*
 * Package for the analog output card host port: register offsets, field
 * positions, reset values, timing counts and bus carrier structs.
 * Assumes a single 40 MHz core clock and an AXI4-Lite master on the host side.
 */
// Functional notes
// (RQ1) each converter word takes 2.2 us to shift out to its converter
// (RQ2) host waits 2.2 us after one converter word before the next one
// (RQ3) transfer status bit reads 1 while shifting, 0 when idle
// (RQ4) host should check status clear before writing a converter word
// (RQ5) four digital inputs appear in bits 7..4 of the input read word
// (RQ6) four digital outputs driven from a host-written value 0..15
// (RQ7) host-writable mode selects one of three voltage-to-current ranges
// (RQ8) mode 1 is 0-20 mA, mode 2 is 4-20 mA, mode 3 is 5-25 mA
// (RQ9) one range register applies to all eight current channels together
// (RQ10) converter words are 16-bit two's complement, 0x8000 to 0x7FFF
// (RQ11) status sets on the accepting cycle, clears when the shift completes
package aout_card_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CONV_DATA   = 8'h00;
	localparam logic [7:0] OFS_CONV_STATUS = 8'h04;
	localparam logic [7:0] OFS_INPUT_PORT  = 8'h08;
	localparam logic [7:0] OFS_OUTPUT_PORT = 8'h0C;
	localparam logic [7:0] OFS_RANGE_SEL   = 8'h10;

	// field positions
	localparam int CONV_DATA_LSB  = 0;
	localparam int CONV_CHAN_LSB  = 16;
	localparam int CHAN_W         = 4;
	localparam int INPUT_PORT_LSB = 4;
	localparam int BUSY_BIT       = 0;

	// reset values
	localparam logic [3:0] OUTPUT_PORT_RST = 4'h0;
	localparam logic [1:0] RANGE_SEL_RST   = 2'h1;

	// range modes
	localparam logic [1:0] RANGE_0_20MA = 2'h1;
	localparam logic [1:0] RANGE_4_20MA = 2'h2;
	localparam logic [1:0] RANGE_5_25MA = 2'h3;

	// timing
	localparam int CLK_PERIOD_PS   = 25000;
	localparam int TRANSFER_NS_X10 = 22; // 2.2 us written as 22 tenths of a microsecond
	localparam int TRANSFER_PS     = TRANSFER_NS_X10 * 100000;
	localparam int TRANSFER_CYCLES = TRANSFER_PS / CLK_PERIOD_PS;
	localparam int WORD_BITS       = 24;
	localparam int BIT_CYCLES      = 3; // 24 bits at 3 cycles fit inside the 88-cycle transfer

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0]  chan;
		logic [15:0] data;
	} conv_word_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} rd_beat_t;
endpackage : aout_card_pkg

// ---- logic/aout_card_port.sv ----
/*
 * Host port of the analog output card: AXI4-Lite register slave, serial
 * converter shifter with busy flag, digital in/out ports, range selector.
 * Assumes din pins are asynchronous and the converter latches on frame end.
 */
`timescale 1ns/10ps
module aout_card_port #(
	parameter int XFER_CYCLES = aout_card_pkg::TRANSFER_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [3:0]  din_pins,
	output logic [3:0]       dout_pins,
	output logic [1:0]       voltage_to_current_range_select,
	output logic             conv_sclk,
	output logic             conv_sdata,
	output logic             conv_frame
);
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic [3:0]  din_meta;
	logic [3:0]  input_port_value;
	logic [3:0]  output_port_value;
	logic        converter_transfer_busy;
	logic [15:0] xfer_cnt;
	logic [aout_card_pkg::WORD_BITS-1:0] shreg;
	logic [1:0]  bit_phase;
	logic [4:0]  bits_left;
	aout_card_pkg::rd_beat_t rd_beat;
	aout_card_pkg::conv_word_t conv_in;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		addr_is = (a[7:2] == ofs[7:2]);
	endfunction : addr_is

	// address and data are caught independently, either may come first
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign conv_in       = aout_card_pkg::conv_word_t'({w_data[19:16], w_data[15:0]});

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= aout_card_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (addr_is(aw_addr, aout_card_pkg::OFS_CONV_DATA) ||
				addr_is(aw_addr, aout_card_pkg::OFS_OUTPUT_PORT) ||
				addr_is(aw_addr, aout_card_pkg::OFS_RANGE_SEL) ||
				addr_is(aw_addr, aout_card_pkg::OFS_CONV_STATUS) ||
				addr_is(aw_addr, aout_card_pkg::OFS_INPUT_PORT)) ?
				aout_card_pkg::RESP_OKAY : aout_card_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// digital outputs, low byte lane only
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			output_port_value <= aout_card_pkg::OUTPUT_PORT_RST;
		end else if (wr_fire && w_strb[0] && addr_is(aw_addr, aout_card_pkg::OFS_OUTPUT_PORT)) begin
			output_port_value <= w_data[3:0]; // [RQ6]
		end
	end
	assign dout_pins = output_port_value;

	// one range setting shared by all eight current channels; mode 0 ignored
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			voltage_to_current_range_select <= aout_card_pkg::RANGE_SEL_RST;
		end else if (wr_fire && w_strb[0] && addr_is(aw_addr, aout_card_pkg::OFS_RANGE_SEL) &&
			w_data[1:0] != 2'h0) begin
			voltage_to_current_range_select <= w_data[1:0]; // [RQ7] [RQ8] [RQ9]
		end
	end

	// input pins pass two flops before anything reads them
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			din_meta         <= 4'h0;
			input_port_value <= 4'h0;
		end else begin
			din_meta         <= din_pins;
			input_port_value <= din_meta;
		end
	end

	// converter shifter: a write while busy is dropped, host must pace itself
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			converter_transfer_busy <= 1'b0;
			xfer_cnt                <= 16'h0000;
		end else if (wr_fire && !converter_transfer_busy && (w_strb[1:0] == 2'h3) &&
			addr_is(aw_addr, aout_card_pkg::OFS_CONV_DATA)) begin
			converter_transfer_busy <= 1'b1; // [RQ11] [RQ3]
			xfer_cnt                <= 16'(XFER_CYCLES - 1); // [RQ1]
		end else if (converter_transfer_busy) begin
			if (xfer_cnt == 16'h0000) begin
				converter_transfer_busy <= 1'b0; // [RQ11]
			end else begin
				xfer_cnt <= xfer_cnt - 16'h0001;
			end
		end
	end

	// bit pacing kept apart from the transfer timer so the word always ends before busy drops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			shreg     <= '0;
			bit_phase <= 2'h0;
			bits_left <= 5'h00;
		end else if (wr_fire && !converter_transfer_busy && (w_strb[1:0] == 2'h3) &&
			addr_is(aw_addr, aout_card_pkg::OFS_CONV_DATA)) begin
			shreg     <= {4'h0, conv_in}; // [RQ10]
			bit_phase <= 2'h0;
			bits_left <= 5'(aout_card_pkg::WORD_BITS);
		end else if (converter_transfer_busy && bits_left != 5'h00) begin
			if (bit_phase == 2'(aout_card_pkg::BIT_CYCLES - 1)) begin
				bit_phase <= 2'h0;
				bits_left <= bits_left - 5'h01;
				shreg     <= {shreg[aout_card_pkg::WORD_BITS-2:0], 1'b0};
			end else begin
				bit_phase <= bit_phase + 2'h1;
			end
		end
	end

	// serial pins: msb first, clock high in the middle cycle of each 3-cycle bit
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_sclk  <= 1'b0;
			conv_sdata <= 1'b0;
			conv_frame <= 1'b0;
		end else begin
			conv_frame <= converter_transfer_busy;
			conv_sdata <= shreg[aout_card_pkg::WORD_BITS-1];
			conv_sclk  <= converter_transfer_busy && bits_left != 5'h00 && bit_phase == 2'h1;
		end
	end

	// read path, one cycle latency
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		rd_beat.resp = aout_card_pkg::RESP_OKAY;
		rd_beat.data = 32'h00000000;
		if (addr_is(s_axi_araddr, aout_card_pkg::OFS_CONV_STATUS)) begin
			rd_beat.data[aout_card_pkg::BUSY_BIT] = converter_transfer_busy; // [RQ3]
		end else if (addr_is(s_axi_araddr, aout_card_pkg::OFS_INPUT_PORT)) begin
			rd_beat.data[7:4] = input_port_value; // [RQ5]
		end else if (addr_is(s_axi_araddr, aout_card_pkg::OFS_OUTPUT_PORT)) begin
			rd_beat.data[3:0] = output_port_value;
		end else if (addr_is(s_axi_araddr, aout_card_pkg::OFS_RANGE_SEL)) begin
			rd_beat.data[1:0] = voltage_to_current_range_select;
		end else if (!addr_is(s_axi_araddr, aout_card_pkg::OFS_CONV_DATA)) begin
			rd_beat.resp = aout_card_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= aout_card_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_beat.data;
			s_axi_rresp  <= rd_beat.resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// assertions
	logic conv_start;
	assign conv_start = wr_fire && !converter_transfer_busy && (w_strb[1:0] == 2'h3) &&
		addr_is(aw_addr, aout_card_pkg::OFS_CONV_DATA);

	sequence s_busy_run;
		converter_transfer_busy [*8];
	endsequence

	property p_busy_sets;
		@(posedge core_clk) disable iff (!arst_n) conv_start |=> s_busy_run;
	endproperty
	a_busy_sets: assert property (p_busy_sets) else $error("busy did not hold after start"); // [RQ11]

	sequence s_busy_drops;
		converter_transfer_busy ##1 !converter_transfer_busy;
	endsequence

	// busy stands exactly the 88 transfer cycles, then falls
	property p_busy_ends;
		@(posedge core_clk) disable iff (!arst_n) conv_start |=> ##87 s_busy_drops;
	endproperty
	a_busy_ends: assert property (p_busy_ends) else $error("transfer overran"); // [RQ1]

	property p_status_read;
		@(posedge core_clk) disable iff (!arst_n)
			(s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, aout_card_pkg::OFS_CONV_STATUS))
			|=> s_axi_rdata[0] == $past(converter_transfer_busy);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong"); // [RQ3]

	property p_din_read;
		@(posedge core_clk) disable iff (!arst_n)
			(s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, aout_card_pkg::OFS_INPUT_PORT))
			|=> s_axi_rdata[7:4] == $past(input_port_value) && s_axi_rdata[3:0] == 4'h0;
	endproperty
	a_din_read: assert property (p_din_read) else $error("input port read wrong"); // [RQ5]

	property p_dout;
		@(posedge core_clk) disable iff (!arst_n)
			(wr_fire && w_strb[0] && addr_is(aw_addr, aout_card_pkg::OFS_OUTPUT_PORT))
			|=> dout_pins == $past(w_data[3:0]);
	endproperty
	a_dout: assert property (p_dout) else $error("output port not updated"); // [RQ6]

	property p_range_legal;
		@(posedge core_clk) disable iff (!arst_n) voltage_to_current_range_select != 2'h0;
	endproperty
	a_range_legal: assert property (p_range_legal) else $error("range mode illegal"); // [RQ8]

	property p_range_set;
		@(posedge core_clk) disable iff (!arst_n)
			(wr_fire && w_strb[0] && addr_is(aw_addr, aout_card_pkg::OFS_RANGE_SEL) && w_data[1:0] != 2'h0)
			|=> voltage_to_current_range_select == $past(w_data[1:0]);
	endproperty
	a_range_set: assert property (p_range_set) else $error("range mode not taken"); // [RQ7] [RQ9]

	property p_word_loaded;
		@(posedge core_clk) disable iff (!arst_n)
			conv_start |=> shreg[15:0] == $past(w_data[15:0]);
	endproperty
	a_word_loaded: assert property (p_word_loaded) else $error("converter word not loaded"); // [RQ10]
endmodule : aout_card_port

// ---- bench/conv_model.sv ----
/* converter receiver model: shifts in the serial word and times the frame.
 * assumes the pins change only just after core_clk edges. */
`timescale 1ns/10ps
module conv_model (
	input  wire logic        core_clk,
	input  wire logic        conv_sclk,
	input  wire logic        conv_sdata,
	input  wire logic        conv_frame,
	output logic [23:0]      rx_word,
	output logic [7:0]       rx_bits,
	output logic [15:0]      frame_len,
	output logic [7:0]       frames
);
	logic        sclk_q = 1'b0;
	logic        frame_q = 1'b0;
	logic [23:0] shift;
	logic [7:0]  nbits = 8'h00;
	logic [15:0] len = 16'h0000;
	initial frames = 8'h00;
	// sample on sclk rise, whole word taken only at frame end
	always @(posedge core_clk) begin
		sclk_q <= conv_sclk;
		frame_q <= conv_frame;
		len <= conv_frame ? len + 16'h0001 : 16'h0000;
		if (conv_frame && conv_sclk && !sclk_q) begin
			shift <= {shift[22:0], conv_sdata}; // msb first
			nbits <= nbits + 8'h01;
		end
		if (frame_q && !conv_frame) begin
			rx_word <= shift;
			rx_bits <= nbits;
			frame_len <= len;
			frames <= frames + 8'h01;
			nbits <= 8'h00;
		end
	end
endmodule : conv_model

// ---- bench/analog_output_card_host_port_tb.sv ----
/* testbench for the card host port: bus tasks, register rows, converter,
 * input port and reset cases. assumes the bus answers within 60 cycles. */
`timescale 1ns/10ps
module analog_output_card_host_port_tb;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] q; logic [1:0] b, r;} row_t;
	localparam logic [1:0] OK = aout_card_pkg::RESP_OKAY;
	localparam logic [1:0] ER = aout_card_pkg::RESP_SLVERR;
	localparam int         XF = 2200 / 25;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_bits, frames;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb, din_pins, dout_pins;
	logic [1:0]  s_axi_bresp, s_axi_rresp, voltage_to_current_range_select, b, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conv_sclk, conv_sdata, conv_frame;
	logic [23:0] rx_word;
	logic [15:0] frame_len;
	int          err_total = 0, checks = 0, i, n;
	// writes of 0 to the range and a missing low strobe leave the old value
	row_t        rows [8] = '{'{8'h0C, 32'h5, 4'hF, 32'h5, OK, OK}, '{8'h0C, 32'hFFFFFFFA, 4'hF, 32'hA, OK, OK},
		'{8'h0C, 32'h3, 4'hE, 32'hA, OK, OK}, '{8'h10, 32'h1, 4'hF, 32'h1, OK, OK},
		'{8'h10, 32'h2, 4'hF, 32'h2, OK, OK}, '{8'h10, 32'h3, 4'hF, 32'h3, OK, OK},
		'{8'h10, 32'h0, 4'hF, 32'h3, OK, OK}, '{8'h14, 32'h12345678, 4'hF, 32'h0, ER, ER}};
	aout_card_port #(.XFER_CYCLES(XF)) dut (
		.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.din_pins, .dout_pins, .voltage_to_current_range_select, .conv_sclk, .conv_sdata, .conv_frame);
	conv_model far (.core_clk, .conv_sclk, .conv_sdata, .conv_frame, .rx_word, .rx_bits, .frame_len, .frames);
	always #12.5 core_clk = ~core_clk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic hang();
		err_total++;
		$display("unexpected t=%0t wait ran out", $time);
		final_report();
	endtask : hang
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// handshakes are judged at the negedge, released just after the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, done;
		done = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int k = 0; k < 60 && !done; k++) begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid === 1'b1;
			b = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (done) s_axi_bready <= 1'b0;
		end
		if (!done) hang();
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ta, done;
		done = 1'b0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (int k = 0; k < 60 && !done; k++) begin
			@(negedge core_clk);
			ta = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid === 1'b1;
			q = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (done) s_axi_rready <= 1'b0;
		end
		if (!done) hang();
	endtask : rd
	task automatic wt(input logic [7:0] f);
		for (int k = 0; k < 300 && frames !== f; k++) @(posedge core_clk);
		if (frames !== f) hang();
	endtask : wt
	// reset for two cycles, then idle outputs and status
	task automatic rst();
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
		chk({28'h0, dout_pins}, 32'h0);
		chk({30'h0, voltage_to_current_range_select}, 32'h1);
		chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h7);
		chk({30'h0, s_axi_bvalid, s_axi_rvalid}, 32'h0);
		rd(8'h04);
		chk(q, 32'h0);
		rd(8'h00);
		chk(q, 32'h0);
		$display("test reset done");
	endtask : rst
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		din_pins = 4'h9;
		rst();
		for (i = 0; i < 8; i++) begin
			wr(rows[i].a, rows[i].d, rows[i].s);
			chk({30'h0, b}, {30'h0, rows[i].b});
			rd(rows[i].a);
			chk(q, rows[i].q);
			chk({30'h0, r}, {30'h0, rows[i].r});
			if (rows[i].a == 8'h0C) chk({28'h0, dout_pins}, rows[i].q);
			if (rows[i].a == 8'h10) chk({30'h0, voltage_to_current_range_select}, rows[i].q);
		end
		$display("test rows done");
		for (i = 0; i < 2; i++) begin
			din_pins <= i ? 4'h6 : 4'h9;
			repeat (3) @(posedge core_clk);
			rd(8'h08);
			chk(q & 32'hF0, i ? 32'h60 : 32'h90);
		end
		$display("test input port done");
		// second word lands while busy and must be dropped
		wr(8'h00, 32'h00058000, 4'hF);
		rd(8'h04);
		chk(q & 32'h1, 32'h1);
		wr(8'h00, 32'h00021234, 4'hF);
		chk({30'h0, b}, 32'h0);
		q = 32'h1;
		for (n = 0; n < 100 && q[0]; n++) rd(8'h04);
		if (q[0]) hang();
		wt(8'h01);
		chk({8'h0, rx_word}, 32'h00058000);
		chk({24'h0, rx_bits}, 32'h18);
		chk({16'h0, frame_len}, 32'(XF));
		wr(8'h00, 32'h00027FFF, 4'hF);
		wt(8'h02);
		chk({8'h0, rx_word}, 32'h00027FFF);
		$display("test converter done");
		rst();
		final_report();
	end
endmodule : analog_output_card_host_port_tb
